// ### hdl/status_output_selector.sv
`timescale 1ns/10ps
// Function
// - five selectors, codes 0..64, reset 0; code 0 keeps terminal off
// - code 1: on while drive running
// - code 2: on while stopped by fault
// - code 3: on while brake release conditions met
// - code 4: on while run command received
// - code 5: on while drive ready to run
// - codes 6..9: on while speed step 0..3 active
// - code 11: on while direction command active
// - code 12: on while any fault present
// - code 13: on while motor overheat fault present
// - code 14: on while motor overload fault present
// - code 15: on while motor overspeed fault present
// - codes 17..20: on while motor 1..4 selected
// - code 22: on while output frequency below speed limit
// - codes 49..53: follow fieldbus function bits 1..5
// - codes 61..64: follow free function blocks 1..4
// - four block settings, 0..500, reset 0
module status_output_selector (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic drive_running,
   input wire logic fault_stopped,
   input wire logic brake_release,
   input wire logic run_request,
   input wire logic drive_ready,
   input wire logic [3:0] speed_step,
   input wire logic direction_cmd,
   input wire logic fault_present,
   input wire logic overheat_warn,
   input wire logic overload_warn,
   input wire logic overspeed_warn,
   input wire logic [3:0] motor_selected,
   input wire logic below_speed_limit,
   input wire logic above_speed_limit,
   input wire logic [4:0] fieldbus_bits,
   input wire logic [3:0] block_result,
   output logic output_terminal_1,
   output logic output_terminal_2,
   output logic output_terminal_3,
   output logic output_terminal_4,
   output logic output_terminal_5,
   output logic [8:0] logic_block_setting_1,
   output logic [8:0] logic_block_setting_2,
   output logic [8:0] logic_block_setting_3,
   output logic [8:0] logic_block_setting_4
);
   import status_output_pkg::*;

   // ****************************************
   // state
   // ****************************************
   // synchronised conditions, drive_running in bit 0
   typedef struct packed {
      logic above_speed_limit;
      logic below_speed_limit;
      logic [3:0] block_result;
      logic [4:0] fieldbus_bits;
      logic [3:0] motor_selected;
      logic overspeed_warn;
      logic overload_warn;
      logic overheat_warn;
      logic fault_present;
      logic direction_cmd;
      logic [3:0] speed_step;
      logic drive_ready;
      logic run_request;
      logic brake_release;
      logic fault_stopped;
      logic drive_running;
   } cond_t;

   typedef struct packed {
      cond_t sync1;
      cond_t sync2;
      logic [terminal_count-1:0][select_width-1:0] select;
      logic [setting_count-1:0][setting_width-1:0] setting;
      logic [terminal_count-1:0] terminal;
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic [31:0] rdata;
      logic ready;
      logic resp;
   } state_t;

   // bus idles ready with an okay response
   localparam state_t state_reset = '{ready: 1'b1, default: '0};

   state_t r;
   state_t next_r;
   cond_t cond_now;
   logic [terminal_count-1:0] term_value;

   // ****************************************
   // condition pins into the two-stage synchroniser
   // ****************************************
   always_comb begin
      cond_now.above_speed_limit = above_speed_limit;
      cond_now.below_speed_limit = below_speed_limit;
      cond_now.block_result = block_result;
      cond_now.fieldbus_bits = fieldbus_bits;
      cond_now.motor_selected = motor_selected;
      cond_now.overspeed_warn = overspeed_warn;
      cond_now.overload_warn = overload_warn;
      cond_now.overheat_warn = overheat_warn;
      cond_now.fault_present = fault_present;
      cond_now.direction_cmd = direction_cmd;
      cond_now.speed_step = speed_step;
      cond_now.drive_ready = drive_ready;
      cond_now.run_request = run_request;
      cond_now.brake_release = brake_release;
      cond_now.fault_stopped = fault_stopped;
      cond_now.drive_running = drive_running;
   end

   // ****************************************
   // per-terminal selector
   // ****************************************
   function automatic logic select_cond(input logic [6:0] code, input logic [31:0] c);
      logic v;
      v = 1'b0;
      if (code == code_run) begin
         v = c[0];
      end else if (code == code_fault) begin
         v = c[1];
      end else if (code == code_brake) begin
         v = c[2];
      end else if (code == code_run_request) begin
         v = c[3];
      end else if (code == code_ready) begin
         v = c[4];
      end else if (code == code_step_first) begin
         v = c[5];
      end else if (code == code_step_first + 7'h01) begin
         v = c[6];
      end else if (code == code_step_first + 7'h02) begin
         v = c[7];
      end else if (code == code_step_last) begin
         v = c[8];
      end else if (code == code_direction) begin
         v = c[9];
      end else if (code == code_warning) begin
         v = c[10];
      end else if (code == code_overheat) begin
         v = c[11];
      end else if (code == code_overload) begin
         v = c[12];
      end else if (code == code_overspeed) begin
         v = c[13];
      end else if (code == code_motor_first) begin
         v = c[14];
      end else if (code == code_motor_first + 7'h01) begin
         v = c[15];
      end else if (code == code_motor_first + 7'h02) begin
         v = c[16];
      end else if (code == code_motor_last) begin
         v = c[17];
      end else if (code == code_fieldbus_first) begin
         v = c[18];
      end else if (code == code_fieldbus_first + 7'h01) begin
         v = c[19];
      end else if (code == code_fieldbus_first + 7'h02) begin
         v = c[20];
      end else if (code == code_fieldbus_first + 7'h03) begin
         v = c[21];
      end else if (code == code_fieldbus_last) begin
         v = c[22];
      end else if (code == code_block_first) begin
         v = c[23];
      end else if (code == code_block_first + 7'h01) begin
         v = c[24];
      end else if (code == code_block_first + 7'h02) begin
         v = c[25];
      end else if (code == code_block_last) begin
         v = c[26];
      end else if (code == code_low_speed) begin
         v = c[27];
      end else if (code == code_high_speed) begin
         v = c[28];
      end else begin
         v = 1'b0;
      end
      return v;
   endfunction : select_cond

   genvar gi;
   generate
      for (gi = 0; gi < terminal_count; gi++) begin : g_term
         assign term_value[gi] = select_cond(r.select[gi], {3'h0, r.sync2});
      end
   endgenerate

   // ****************************************
   // bus and register update
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.sync1 = cond_now;
      next_r.sync2 = r.sync1;
      next_r.terminal = term_value;
      next_r.wr_pend = 1'b0;
      next_r.rd_pend = 1'b0;
      next_r.ready = 1'b1;
      next_r.resp = 1'b0;
      // data phase of a write: out-of-range values leave the register alone
      if (r.wr_pend) begin
         if (r.addr == output_1_function_select_addr) begin
            if (hwdata <= 32'(select_max)) begin
               next_r.select[0] = hwdata[6:0];
            end
         end else if (r.addr == output_2_function_select_addr) begin
            if (hwdata <= 32'(select_max)) begin
               next_r.select[1] = hwdata[6:0];
            end
         end else if (r.addr == output_3_function_select_addr) begin
            if (hwdata <= 32'(select_max)) begin
               next_r.select[2] = hwdata[6:0];
            end
         end else if (r.addr == output_4_function_select_addr) begin
            if (hwdata <= 32'(select_max)) begin
               next_r.select[3] = hwdata[6:0];
            end
         end else if (r.addr == output_5_function_select_addr) begin
            if (hwdata <= 32'(select_max)) begin
               next_r.select[4] = hwdata[6:0];
            end
         end else if (r.addr == logic_block_setting_1_addr) begin
            if (hwdata <= 32'(setting_max)) begin
               next_r.setting[0] = hwdata[8:0];
            end
         end else if (r.addr == logic_block_setting_2_addr) begin
            if (hwdata <= 32'(setting_max)) begin
               next_r.setting[1] = hwdata[8:0];
            end
         end else if (r.addr == logic_block_setting_3_addr) begin
            if (hwdata <= 32'(setting_max)) begin
               next_r.setting[2] = hwdata[8:0];
            end
         end else if (r.addr == logic_block_setting_4_addr) begin
            if (hwdata <= 32'(setting_max)) begin
               next_r.setting[3] = hwdata[8:0];
            end
         end
      end
      // address phase; read data stands until the next read is accepted
      if (hsel && hready && htrans == htrans_nonseq) begin
         next_r.addr = haddr;
         next_r.wr_pend = hwrite;
         next_r.rd_pend = !hwrite;
         if (!hwrite) begin
            if (haddr == output_1_function_select_addr) begin
               next_r.rdata = {25'h0, r.select[0]};
            end else if (haddr == output_2_function_select_addr) begin
               next_r.rdata = {25'h0, r.select[1]};
            end else if (haddr == output_3_function_select_addr) begin
               next_r.rdata = {25'h0, r.select[2]};
            end else if (haddr == output_4_function_select_addr) begin
               next_r.rdata = {25'h0, r.select[3]};
            end else if (haddr == output_5_function_select_addr) begin
               next_r.rdata = {25'h0, r.select[4]};
            end else if (haddr == logic_block_setting_1_addr) begin
               next_r.rdata = {23'h0, r.setting[0]};
            end else if (haddr == logic_block_setting_2_addr) begin
               next_r.rdata = {23'h0, r.setting[1]};
            end else if (haddr == logic_block_setting_3_addr) begin
               next_r.rdata = {23'h0, r.setting[2]};
            end else if (haddr == logic_block_setting_4_addr) begin
               next_r.rdata = {23'h0, r.setting[3]};
            end else if (haddr == terminal_status_addr) begin
               next_r.rdata = {27'h0, r.terminal};
            end else begin
               next_r.rdata = 32'h00000000;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= state_reset;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign hrdata = r.rdata;
   assign hreadyout = r.ready;
   assign hresp = r.resp;
   assign output_terminal_1 = r.terminal[0];
   assign output_terminal_2 = r.terminal[1];
   assign output_terminal_3 = r.terminal[2];
   assign output_terminal_4 = r.terminal[3];
   assign output_terminal_5 = r.terminal[4];
   assign logic_block_setting_1 = r.setting[0];
   assign logic_block_setting_2 = r.setting[1];
   assign logic_block_setting_3 = r.setting[2];
   assign logic_block_setting_4 = r.setting[3];
endmodule : status_output_selector

// ### hdl/status_output_pkg.sv
package status_output_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] output_1_function_select_addr = 8'h00;
   localparam logic [7:0] output_2_function_select_addr = 8'h04;
   localparam logic [7:0] output_3_function_select_addr = 8'h08;
   localparam logic [7:0] output_4_function_select_addr = 8'h0c;
   localparam logic [7:0] output_5_function_select_addr = 8'h10;
   localparam logic [7:0] logic_block_setting_1_addr = 8'h40;
   localparam logic [7:0] logic_block_setting_2_addr = 8'h44;
   localparam logic [7:0] logic_block_setting_3_addr = 8'h48;
   localparam logic [7:0] logic_block_setting_4_addr = 8'h4c;
   localparam logic [7:0] terminal_status_addr = 8'h50;
   localparam int select_width = 7;
   localparam int setting_width = 9;
   localparam int terminal_count = 5;
   localparam int setting_count = 4;
   localparam logic [6:0] select_reset = 7'h00;
   localparam logic [8:0] setting_reset = 9'h000;
   localparam logic [6:0] select_max = 7'h40;
   localparam logic [8:0] setting_max = 9'h1f4;
   // ****************************************
   // function codes
   // ****************************************
   localparam logic [6:0] code_disabled = 7'h00;
   localparam logic [6:0] code_run = 7'h01;
   localparam logic [6:0] code_fault = 7'h02;
   localparam logic [6:0] code_brake = 7'h03;
   localparam logic [6:0] code_run_request = 7'h04;
   localparam logic [6:0] code_ready = 7'h05;
   localparam logic [6:0] code_step_first = 7'h06;
   localparam logic [6:0] code_step_last = 7'h09;
   localparam logic [6:0] code_direction = 7'h0b;
   localparam logic [6:0] code_warning = 7'h0c;
   localparam logic [6:0] code_overheat = 7'h0d;
   localparam logic [6:0] code_overload = 7'h0e;
   localparam logic [6:0] code_overspeed = 7'h0f;
   localparam logic [6:0] code_motor_first = 7'h11;
   localparam logic [6:0] code_motor_last = 7'h14;
   localparam logic [6:0] code_low_speed = 7'h16;
   localparam logic [6:0] code_high_speed = 7'h17;
   localparam logic [6:0] code_fieldbus_first = 7'h31;
   localparam logic [6:0] code_fieldbus_last = 7'h35;
   localparam logic [6:0] code_block_first = 7'h3d;
   localparam logic [6:0] code_block_last = 7'h40;
   localparam logic [1:0] htrans_nonseq = 2'h2;
   localparam logic [2:0] hsize_word = 3'h2;
endpackage : status_output_pkg

// ### testbench/status_output_selector_assertions.sv
`timescale 1ns/10ps
// ********
// bus and terminal checks
// ********
module status_output_selector_assertions (
   input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic [31:0] hwdata, hrdata,
   input wire logic [8:0] logic_block_setting_1,
   input wire logic output_terminal_1, output_terminal_2, output_terminal_3,
   input wire logic output_terminal_4, output_terminal_5,
   input wire logic drive_running, fault_stopped, brake_release, run_request, drive_ready,
   input wire logic direction_cmd, fault_present, overheat_warn, overload_warn, overspeed_warn,
   input wire logic below_speed_limit, above_speed_limit,
   input wire logic [3:0] speed_step, motor_selected, block_result,
   input wire logic [4:0] fieldbus_bits
);
   logic [28:0] cond;
   logic [4:0] term;
   logic acc, wr, rd, wr40;
   assign cond = {block_result, fieldbus_bits, above_speed_limit, below_speed_limit,
      motor_selected, overspeed_warn, overload_warn, overheat_warn, fault_present,
      direction_cmd, speed_step, drive_ready, run_request, brake_release, fault_stopped,
      drive_running};
   assign term = {output_terminal_5, output_terminal_4, output_terminal_3, output_terminal_2,
      output_terminal_1};
   assign acc = hsel && hready && htrans == 2'h2;
   assign wr = acc && hwrite;
   assign rd = acc && !hwrite;
   assign wr40 = wr && haddr == 8'h40;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_ready; hreadyout; endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low");
   property p_resp; !hresp; endproperty
   a_resp: assert property (p_resp) else $error("hresp not okay");
   property p_set_range; logic_block_setting_1 <= 9'h1f4; endproperty
   a_set_range: assert property (p_set_range) else $error("setting above limit");
   property p_set_write; $changed(logic_block_setting_1) |->
      $past(wr40, 2) && {23'h0, logic_block_setting_1} == $past(hwdata); endproperty
   a_set_write: assert property (p_set_write) else $error("setting changed wrongly");
   property p_set_read; rd && haddr == 8'h40 |=>
      hrdata == {23'h0, $past(logic_block_setting_1)}; endproperty
   a_set_read: assert property (p_set_read) else $error("setting read wrong");
   property p_rd_hold; !$past(rd) |-> $stable(hrdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_off; (cond == 29'h0) [*3] |=> term == 5'h00; endproperty
   a_off: assert property (p_off) else $error("terminal on without source");
   property p_stable; ($stable(cond) && !wr) [*5] |=> $stable(term); endproperty
   a_stable: assert property (p_stable) else $error("terminal moved without cause");
endmodule : status_output_selector_assertions
bind status_output_selector status_output_selector_assertions u_sva (.*);

// ### testbench/relay_bank.sv
`timescale 1ns/10ps
// ********
// relay coils on the terminals, one cycle contact lag
// ********
module relay_bank (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [4:0] coil,
   output logic [4:0] contact
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) contact <= 5'h00;
      else contact <= coil;
   end
endmodule : relay_bank

// ### testbench/status_output_selector_test.sv
`timescale 1ns/10ps
module status_output_selector_test;
   import status_output_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, r;
   logic [28:0] cond;
   wire hready;
   wire [4:0] term;
   wire [8:0] setp [4];
   int m [32];
   int bad_count, n_checks, cyc, i, c;
   assign hready = hreadyout;
   status_output_selector u_status_output_selector (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .drive_running(cond[0]), .fault_stopped(cond[1]), .brake_release(cond[2]),
      .run_request(cond[3]), .drive_ready(cond[4]), .speed_step(cond[8:5]),
      .direction_cmd(cond[9]), .fault_present(cond[10]), .overheat_warn(cond[11]),
      .overload_warn(cond[12]), .overspeed_warn(cond[13]), .motor_selected(cond[17:14]),
      .below_speed_limit(cond[18]), .above_speed_limit(cond[19]),
      .fieldbus_bits(cond[24:20]), .block_result(cond[28:25]), .output_terminal_1(term[0]),
      .output_terminal_2(term[1]), .output_terminal_3(term[2]), .output_terminal_4(term[3]),
      .output_terminal_5(term[4]), .logic_block_setting_1(setp[0]),
      .logic_block_setting_2(setp[1]), .logic_block_setting_3(setp[2]),
      .logic_block_setting_4(setp[3]));
   relay_bank u_relay_bank (.hclk(hclk), .hresetn(hresetn), .coil(term), .contact());
   // ********
   // reference model and bus tasks
   // ********
   function automatic logic f_exp(input int c, input logic [28:0] v);
      int k;
      k = c inside {[1:9]} ? c - 1 : c inside {[11:15]} ? c - 2 : c inside {[17:20]} ? c - 3 :
         c inside {[22:23]} ? c - 4 : c inside {[49:53]} ? c - 29 : c inside {[61:64]} ? c - 36 : -1;
      return k < 0 ? 1'b0 : v[k];
   endfunction : f_exp
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= htrans_nonseq; hwrite <= w; haddr <= a;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : xfer
   task automatic wr(input int a, input int d);
      xfer(1'b1, 8'(a), 32'(d));
      if (a < 20 && d < 65) m[a / 4] = d;
      if (a >= 64 && a < 80 && d < 501) m[a / 4] = d;
   endtask : wr
   task automatic rd(input int a);
      xfer(1'b0, 8'(a), 32'h0);
      chk(r, 32'(m[a / 4]));
   endtask : rd
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
      hsize = hsize_word; hwdata = 32'h0; cond = 29'h0;
      r = $urandom(54366);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (i = 0; i < 21; i++) rd(i * 4);
      // every code on every terminal, random sources
      for (c = 0; c < 65; c++) begin
         for (i = 0; i < 5; i++) wr(i * 4, (c + i * 13) % 65);
         cond <= 29'($urandom);
         repeat (4) @(posedge hclk);
         m[20] = 0;
         for (i = 0; i < 5; i++) begin
            m[20][i] = f_exp(m[i], cond);
            chk(32'(term[i]), 32'(m[20][i]));
         end
         rd(80);
      end
      wr(0, 65);
      wr(4, 127);
      wr(32, 5);
      wr(64, 500);
      wr(68, 501);
      wr(72, $urandom % 501);
      wr(76, 1);
      for (i = 0; i < 21; i++) rd(i * 4);
      for (i = 0; i < 4; i++) chk(32'(setp[i]), 32'(m[16 + i]));
      complete_run();
   end
endmodule : status_output_selector_test
